// *** hw/rail_sequencer_ctl_pins.sv ***
// Purpose: pin driven rail power-up/down sequencer with apb registers
// Assumes: pins and power-good inputs asynchronous, 40 MHz clk
// Notes:   open-drain pins driven low while the matching oe is high
`timescale 1ns/1ps
`default_nettype none
`include "seq_defines.svh"

// Functional notes
// [RULE1] rails follow pin levels and power-good chain
// [RULE2] power enable starts the primary sequence
// [RULE3] host holds domain and reset inputs high
// [RULE4] ddr select: low sleep code, high active
// [RULE5] aux switch follows its input directly
// [RULE6] reset request low forces processor reset low
// [RULE7] reset released 50 ms after request high
// [RULE8] processor reset is active-low power-on reset
// [RULE9] switch controls split full-power and logic domains
// [RULE10] full-power domain low drops its rails
// [RULE11] logic domain low drops its rails
// [RULE12] board may tie domain enables to power
// [RULE13] shared register set drives transceiver ldo
// [RULE14] alternate register set has no effect
// [RULE15] power-down: reset first, then staged 2/4 ms
// [RULE16] next rail waits for previous power-good
module rail_sequencer_ctl_pins #(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire seq_pkg::ctl_pins_type    ctl_pins,
	input  wire logic [`RAIL_COUNT-1:0]   rail_pg,
	input  wire seq_pkg::od_pins_type     od_i,
	output var  seq_pkg::od_pins_type     od_o,
	output var  seq_pkg::od_pins_type     od_oe,
	output var  seq_pkg::rail_enable_type rail_enable,
	output var  logic                     auxiliary_load_switch_en,
	output var  logic [7:0]               memory_buck_code,
	output var  logic [7:0]               transceiver_ldo_code,
	input  wire seq_pkg::apb_req_type     apb_req,
	output var  seq_pkg::apb_rsp_type     apb_rsp
);
	import seq_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	top_state_type          st_reg;
	top_state_type          st_next;
	logic [`SYNC_W-1:0]     sync_q;
	ctl_pins_type           ctl_s;
	logic [`RAIL_COUNT-1:0] pg_s;
	od_pins_type            od_s;

	logic [`RAIL_COUNT-1:0] pg_eff;
	logic [`RAIL_COUNT-1:0] dom_ok;
	logic [`RAIL_COUNT-1:0] pass;
	logic [`RAIL_COUNT-1:0] grow;
	logic                   seq_done;

	logic                   rst_run;
	logic                   rst_done;
	logic                   dn_run;
	logic [7:0]             dn_limit;
	logic                   dn_done;

	logic                   setup_ph;
	logic                   wr_acc;
	logic [31:0]            rd_val;
	logic                   rd_miss;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	pin_sync #(
		.W (`SYNC_W)
	) u_pin_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   ({od_i, rail_pg, ctl_pins}),
		.dout  (sync_q)
	);

	assign ctl_s = ctl_pins_type'(sync_q[`CTL_COUNT-1:0]);
	assign pg_s  = sync_q[`CTL_COUNT+`RAIL_COUNT-1:`CTL_COUNT];
	assign od_s  = od_pins_type'(sync_q[`SYNC_W-1:`CTL_COUNT+`RAIL_COUNT]);

	// ----------------------------------------------------------------
	// delay timers
	// ----------------------------------------------------------------
	ms_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_reset_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.run   (rst_run),
		.limit (`RESET_DELAY_MS),
		.done  (rst_done)
	);

	ms_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_down_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.run   (dn_run),
		.limit (dn_limit),
		.done  (dn_done)
	);

	// [RULE15] stage delay select
	assign dn_run   = (st_reg.state == S_DN_W2) || (st_reg.state == S_DN_W4);
	assign dn_limit = (st_reg.state == S_DN_W4) ? `DN_STAGE2_MS : `DN_STAGE1_MS;

	// ----------------------------------------------------------------
	// power-good chain
	// ----------------------------------------------------------------
	// switch controls have no power-good, they count as good once on
	assign pg_eff = (pg_s & ~`SELF_PG_MASK) | (st_reg.rails & `SELF_PG_MASK);

	// [RULE3] domains gated by host inputs
	// [RULE10] full-power domain gate
	// [RULE11] logic domain gate
	assign dom_ok = ~(`FP_MASK & {`RAIL_COUNT{~ctl_s.full_power_domain_enable}})
		& ~(`LOGIC_MASK & {`RAIL_COUNT{~ctl_s.logic_domain_enable}});

	generate
		for (genvar i = 0; i < `RAIL_COUNT; i++) begin : g_chain
			logic prev;
			if (i == 0) begin : g_first
				assign prev = 1'b1;
			end else begin : g_rest
				assign prev = pass[i-1];
			end

			// [RULE16] advance on previous power-good
			assign pass[i] = dom_ok[i] ? (st_reg.rails[i] & pg_eff[i]) : prev;

			// [RULE1] enable from pins and chain
			assign grow[i] = dom_ok[i] & (st_reg.rails[i] | prev);
		end
	endgenerate

	assign seq_done = pass[`RAIL_COUNT-1];

	// [RULE7] delay runs while request high and rails up
	assign rst_run = (st_reg.state == S_UP) && ctl_s.power_enable_input
		&& ctl_s.reset_request_input && seq_done;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	assign setup_ph = apb_req.psel && !apb_req.penable;
	assign wr_acc   = apb_req.psel && apb_req.penable && apb_req.pwrite;

	always_comb begin
		rd_val  = 32'h0000_0000;
		rd_miss = 1'b0;
		case (apb_req.paddr)
			`REG_CTRL: begin
				rd_val[`CTRL_SPARE_BIT] = st_reg.spare_release;
			end

			`REG_ACTIVE_CODE: begin
				rd_val[7:0] = st_reg.active_code;
			end

			`REG_SLEEP_CODE: begin
				rd_val[7:0] = st_reg.sleep_code;
			end

			`REG_SHARED: begin
				rd_val[7:0] = st_reg.shared_code;
			end

			`REG_ALTERNATE: begin
				rd_val[7:0] = st_reg.alt_code;
			end

			`REG_STATUS: begin
				rd_val = {4'h0, od_s, ctl_s, st_reg.rst_hold, seq_done,
					st_reg.state, st_reg.rails};
			end

			`REG_PG: begin
				rd_val[`RAIL_COUNT-1:0] = pg_s;
			end

			default: begin
				rd_miss = 1'b1;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;

		unique case (st_reg.state)
			S_OFF: begin
				st_next.rails = '0;
				// [RULE2] power enable starts sequence
				if (ctl_s.power_enable_input) begin
					st_next.state = S_UP;
				end
			end

			S_UP: begin
				if (!ctl_s.power_enable_input) begin
					st_next.state = S_DN_RST;
				end else begin
					st_next.rails = grow;
				end
			end

			S_DN_RST: begin
				// [RULE15] first stage after reset assert
				st_next.rails = st_reg.rails & ~`DN_GROUP1;
				st_next.state = S_DN_W2;
			end

			S_DN_W2: begin
				if (dn_done) begin
					st_next.state = S_DN_G2;
				end
			end

			S_DN_G2: begin
				// [RULE15] second stage
				st_next.rails = st_reg.rails & ~`DN_GROUP2;
				st_next.state = S_DN_W4;
			end

			S_DN_W4: begin
				if (dn_done) begin
					// [RULE15] last stage
					st_next.rails = st_reg.rails & ~`DN_GROUP3;
					st_next.state = S_OFF;
				end
			end

			default: begin
				st_next.state = S_OFF;
				st_next.rails = '0;
			end
		endcase

		// [RULE10] domain low keeps its rails off in any state
		// [RULE11] same for logic domain
		st_next.rails = st_next.rails & dom_ok;

		// [RULE6] request low holds reset
		// [RULE15] leaving S_UP asserts reset first
		// [RULE7] release only after delay done
		st_next.rst_hold = !(rst_run && rst_done && ctl_s.power_enable_input);

		// [RULE5] aux switch follows its pin
		st_next.aux_en = ctl_s.aux_switch_enable_input;

		// [RULE4] low selects sleep code (1.2 V), high active (1.1 V)
		st_next.mem_code = ctl_s.ddr_voltage_select ? st_reg.active_code
			: st_reg.sleep_code;

		// apb read data captured in setup, error on unmapped address
		if (setup_ph) begin
			st_next.prdata = rd_val;
			st_next.slverr = rd_miss;
		end

		if (wr_acc) begin
			case (apb_req.paddr)
				`REG_CTRL: begin
					st_next.spare_release = apb_req.pwdata[`CTRL_SPARE_BIT];
				end

				`REG_ACTIVE_CODE: begin
					st_next.active_code = apb_req.pwdata[7:0];
				end

				`REG_SLEEP_CODE: begin
					st_next.sleep_code = apb_req.pwdata[7:0];
				end

				`REG_SHARED: begin
					// [RULE13] shared set drives transceiver ldo
					st_next.shared_code = apb_req.pwdata[7:0];
				end

				`REG_ALTERNATE: begin
					// [RULE14] stored only, drives nothing
					st_next.alt_code = apb_req.pwdata[7:0];
				end

				default: begin
				end
			endcase
		end

		// [RULE9] switch controls pulled low while domain off
		st_next.od_oe.full_power_switch_control = !st_next.rails[`FP_SWITCH_BIT];
		st_next.od_oe.core_switch_control       = !st_next.rails[`CORE_SWITCH_BIT];
		// [RULE8] reset pin pulled low while held
		st_next.od_oe.processor_reset_output    = st_next.rst_hold;
		st_next.od_oe.spare_open_drain_output   = !st_next.spare_release;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg             <= '0;
			st_reg.state       <= S_OFF;
			st_reg.rst_hold    <= 1'b1;
			st_reg.od_oe       <= '1;
			st_reg.active_code <= `ACTIVE_CODE_RST;
			st_reg.sleep_code  <= `SLEEP_CODE_RST;
			st_reg.shared_code <= `SHARED_CODE_RST;
			st_reg.alt_code    <= `ALT_CODE_RST;
			st_reg.mem_code    <= `SLEEP_CODE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign od_o                     = '0;
	assign od_oe                    = st_reg.od_oe;
	assign rail_enable              = rail_enable_type'(st_reg.rails);
	assign auxiliary_load_switch_en = st_reg.aux_en;
	assign memory_buck_code         = st_reg.mem_code;
	// [RULE13] transceiver ldo code output
	assign transceiver_ldo_code     = st_reg.shared_code;

	assign apb_rsp.prdata           = st_reg.prdata;
	assign apb_rsp.pready           = 1'b1;
	assign apb_rsp.pslverr          = st_reg.slverr;
endmodule // rail_sequencer_ctl_pins
`default_nettype wire

// *** hw/seq_defines.svh ***
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 40 MHz system clock
// Notes:   rail bit order follows the power-up chain
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    25
`define TICK_NS          1000000
`define TICK_CYCLES      (`TICK_NS / `CLK_PERIOD_NS)
`define RESET_DELAY_MS   8'd50
`define DN_STAGE1_MS     8'd2
`define DN_STAGE2_MS     8'd4

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define RAIL_COUNT       13
`define CTL_COUNT        6
`define OD_COUNT         4
`define SYNC_W           23

// ----------------------------------------------------------------
// rail groups, bit i = chain position i
// ----------------------------------------------------------------
`define FP_MASK          13'h02c4
`define LOGIC_MASK       13'h1c00
`define SELF_PG_MASK     13'h0404
`define DN_GROUP1        13'h0280
`define DN_GROUP2        13'h1d70
`define DN_GROUP3        13'h000f
`define FP_SWITCH_BIT    2
`define CORE_SWITCH_BIT  10

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define REG_CTRL         8'h00
`define REG_ACTIVE_CODE  8'h04
`define REG_SLEEP_CODE   8'h08
`define REG_SHARED       8'h0c
`define REG_ALTERNATE    8'h10
`define REG_STATUS       8'h14
`define REG_PG           8'h18
`define CTRL_SPARE_BIT   0
`define ACTIVE_CODE_RST  8'h00
`define SLEEP_CODE_RST   8'h00
`define SHARED_CODE_RST  8'h00
`define ALT_CODE_RST     8'h00

`endif

// *** hw/seq_pkg.sv ***
// Purpose: shared types of the rail sequencer
// Assumes: seq_defines.svh gives widths
// Notes:   struct fields listed msb first
`include "seq_defines.svh"
package seq_pkg;

	typedef enum logic [2:0] {
		S_OFF, S_UP, S_DN_RST, S_DN_W2, S_DN_G2, S_DN_W4
	} seq_state_type;

	typedef struct packed {
		logic ddr_voltage_select;
		logic logic_domain_enable;
		logic power_enable_input;
		logic full_power_domain_enable;
		logic aux_switch_enable_input;
		logic reset_request_input;
	} ctl_pins_type;

	typedef struct packed {
		logic core_switch_control;
		logic processor_reset_output;
		logic spare_open_drain_output;
		logic full_power_switch_control;
	} od_pins_type;

	typedef struct packed {
		logic io_bank_ldo;
		logic merged_load_switch;
		logic core_switch;
		logic transceiver_ldo;
		logic periph_3v3_buck;
		logic memory_buck;
		logic termination_ldo;
		logic pll_ldo;
		logic aux_rail_buck;
		logic periph_1v2_buck;
		logic full_power_switch;
		logic low_power_buck;
		logic input_buck;
	} rail_enable_type;

	typedef struct packed {
		logic [7:0]  paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_type;

	typedef struct packed {
		logic [15:0] div;
		logic [7:0]  ms;
	} timer_state_type;

	typedef struct packed {
		seq_state_type            state;
		logic [`RAIL_COUNT-1:0]   rails;
		logic                     rst_hold;
		logic                     aux_en;
		od_pins_type              od_oe;
		logic                     spare_release;
		logic [7:0]               active_code;
		logic [7:0]               sleep_code;
		logic [7:0]               shared_code;
		logic [7:0]               alt_code;
		logic [7:0]               mem_code;
		logic [31:0]              prdata;
		logic                     slverr;
	} top_state_type;

endpackage

// *** hw/pin_sync.sv ***
// Purpose: two-flop synchroniser bank for pin inputs
// Assumes: inputs asynchronous to clk
// Notes:   first stage read only by second stage
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_state_type;

	sync_state_type sync_reg;
	sync_state_type sync_next;

	// ----------------------------------------------------------------
	// two stages
	// ----------------------------------------------------------------
	always_comb begin
		sync_next    = sync_reg;
		sync_next.s1 = din;
		sync_next.s2 = sync_reg.s1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign dout = sync_reg.s2;
endmodule // pin_sync
`default_nettype wire

// *** hw/ms_timer.sv ***
// Purpose: millisecond delay timer on a tick divider
// Assumes: run held high for the whole wait
// Notes:   dropping run restarts both divider and count
`timescale 1ns/1ps
`default_nettype none
module ms_timer #(
	parameter int TICK_CYCLES = 40000
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       run,
	input  wire logic [7:0] limit,
	output var  logic       done
);
	import seq_pkg::*;

	timer_state_type tmr_reg;
	timer_state_type tmr_next;
	logic            tick;

	// ----------------------------------------------------------------
	// divider and ms count
	// ----------------------------------------------------------------
	assign tick = (tmr_reg.div == 16'(TICK_CYCLES - 1));

	always_comb begin
		tmr_next = tmr_reg;
		if (!run) begin
			tmr_next = '0;
		end else if (tmr_reg.ms != limit) begin
			if (tick) begin
				tmr_next.div = '0;
				tmr_next.ms  = tmr_reg.ms + 8'h01;
			end else begin
				tmr_next.div = tmr_reg.div + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tmr_reg <= '0;
		end else begin
			tmr_reg <= tmr_next;
		end
	end

	assign done = run && (tmr_reg.ms == limit);
endmodule // ms_timer
`default_nettype wire

// *** verification/rail_seq_monitor.sv ***
// Purpose: port checker for the rail sequencer
// Assumes: bound into the top module
// Notes:   single clock domain
`timescale 1ns/1ps
`default_nettype none
`include "seq_defines.svh"
module rail_seq_monitor #(
	parameter int TICK_CYCLES = 4
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire seq_pkg::ctl_pins_type    ctl_pins,
	input  wire logic [`RAIL_COUNT-1:0]   rail_pg,
	input  wire seq_pkg::od_pins_type     od_i,
	input  wire seq_pkg::od_pins_type     od_o,
	input  wire seq_pkg::od_pins_type     od_oe,
	input  wire seq_pkg::rail_enable_type rail_enable,
	input  wire logic                     auxiliary_load_switch_en,
	input  wire logic [7:0]               memory_buck_code,
	input  wire logic [7:0]               transceiver_ldo_code,
	input  wire seq_pkg::apb_req_type     apb_req,
	input  wire seq_pkg::apb_rsp_type     apb_rsp
);
	import seq_pkg::*;
	// ----
	// helpers
	// ----
	localparam int RST_WAIT = int'(`RESET_DELAY_MS) * TICK_CYCLES;
	logic [`RAIL_COUNT-1:0] rails;
	logic                   wr_shared;
	logic                   wr_alt;
	int                     hi_cnt_reg;
	assign rails = rail_enable;
	assign wr_shared = apb_req.psel && apb_req.penable && apb_req.pwrite
		&& apb_req.paddr == `REG_SHARED;
	assign wr_alt = apb_req.psel && apb_req.penable && apb_req.pwrite
		&& apb_req.paddr == `REG_ALTERNATE;
	always_ff @(posedge clk) begin
		if (!rst_n || !ctl_pins.reset_request_input)
			hi_cnt_reg <= 0;
		else if (hi_cnt_reg < RST_WAIT)
			hi_cnt_reg <= hi_cnt_reg + 1;
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence req_low; !ctl_pins.reset_request_input [*4]; endsequence
	sequence aux_steady; $stable(ctl_pins.aux_switch_enable_input) [*5]; endsequence
	sequence fp_low; !ctl_pins.full_power_domain_enable [*5]; endsequence
	sequence lg_low; !ctl_pins.logic_domain_enable [*5]; endsequence
	property rise_needs_pg(int i);
		$rose(rails[i]) |-> $past(rail_pg[i-1], 2);
	endproperty
	chk_reset_forced: assert property (req_low |-> od_oe.processor_reset_output)
		else $error("reset output not held low");
	chk_release_wait: assert property (
		$fell(od_oe.processor_reset_output) |-> hi_cnt_reg >= RST_WAIT)
		else $error("reset released early");
	chk_aux_direct: assert property (
		aux_steady |-> auxiliary_load_switch_en == ctl_pins.aux_switch_enable_input)
		else $error("aux switch not following input");
	chk_fp_dropped: assert property (
		fp_low |-> (rails & `FP_MASK) == '0 && od_oe.full_power_switch_control)
		else $error("full-power rails still on");
	chk_logic_dropped: assert property (
		lg_low |-> (rails & `LOGIC_MASK) == '0 && od_oe.core_switch_control)
		else $error("logic rails still on");
	chk_chain_root: assert property (rails[`RAIL_COUNT-1:1] != '0 |-> rails[0])
		else $error("rail on without first rail");
	chk_pg_gate_one: assert property (rise_needs_pg(1))
		else $error("rail 1 rose without power-good");
	chk_pg_gate_four: assert property (rise_needs_pg(4))
		else $error("rail 4 rose without power-good");
	chk_down_order: assert property (
		$fell(rails[0]) |-> $past(od_oe.processor_reset_output, 2))
		else $error("last group off before reset");
	chk_xcvr_written: assert property (
		$changed(transceiver_ldo_code) |-> $past(wr_shared) || $past(wr_shared, 2))
		else $error("transceiver code changed without write");
	chk_alt_inert: assert property ($past(wr_alt) |-> $stable(transceiver_ldo_code))
		else $error("alternate write changed code");
endmodule // rail_seq_monitor
bind rail_sequencer_ctl_pins rail_seq_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_u (
	.clk(clk), .rst_n(rst_n), .ctl_pins(ctl_pins), .rail_pg(rail_pg), .od_i(od_i),
	.od_o(od_o), .od_oe(od_oe), .rail_enable(rail_enable),
	.auxiliary_load_switch_en(auxiliary_load_switch_en), .memory_buck_code(memory_buck_code),
	.transceiver_ldo_code(transceiver_ldo_code), .apb_req(apb_req), .apb_rsp(apb_rsp));
`default_nettype wire

// *** verification/rail_env_model.sv ***
// Purpose: regulator and pull-up model on the rail side
// Assumes: power-good follows each enable after a settle time
// Notes:   slow lengthens settling, pg_block withholds power-good
`timescale 1ns/1ps
`default_nettype none
`include "seq_defines.svh"
module rail_env_model (
	input  wire logic                     clk,
	input  wire seq_pkg::rail_enable_type rail_enable,
	input  wire seq_pkg::od_pins_type     od_oe,
	input  wire logic                     slow,
	input  wire logic [`RAIL_COUNT-1:0]   pg_block,
	output var  logic [`RAIL_COUNT-1:0]   rail_pg,
	output var  seq_pkg::od_pins_type     od_i
);
	import seq_pkg::*;
	logic [3:0] age_reg [`RAIL_COUNT];
	always_ff @(posedge clk) begin
		for (int i = 0; i < `RAIL_COUNT; i++) begin
			if (!rail_enable[i])
				age_reg[i] <= 4'h0;
			else if (age_reg[i] != 4'hf)
				age_reg[i] <= age_reg[i] + 4'h1;
		end
	end
	always_comb begin
		for (int i = 0; i < `RAIL_COUNT; i++)
			rail_pg[i] = age_reg[i] >= (slow ? 4'h9 : 4'h1) && !pg_block[i];
	end
	assign od_i = ~od_oe;
endmodule // rail_env_model
`default_nettype wire

// *** verification/rail_sequencer_ctl_pins_tb.sv ***
// Purpose: self-checking bench for the rail sequencer
// Assumes: TICK_CYCLES of 4, so 1 ms is 4 clocks
// Notes:   reads scored from a queue of expected words
`timescale 1ns/1ps
`default_nettype none
`include "seq_defines.svh"
module rail_sequencer_ctl_pins_tb;
	import seq_pkg::*;
	localparam int TICK = 4;
	logic                   clk;
	logic                   rst_n;
	ctl_pins_type           pins;
	logic [`RAIL_COUNT-1:0] rail_pg;
	logic [`RAIL_COUNT-1:0] pg_block;
	logic                   slow;
	od_pins_type            od_i;
	od_pins_type            od_oe;
	rail_enable_type        rail_enable;
	logic                   aux_en;
	logic [7:0]             mem_code;
	logic [7:0]             xcvr_code;
	apb_req_type            req;
	apb_rsp_type            rsp;
	logic [16:0]            obs;
	logic [32:0]            exp_q[$];
	logic [31:0]            wd[4];
	int                     err_count;
	int                     n_compared;
	int                     cycles;
	int                     seed;
	int                     n;
	assign obs = {od_oe, rail_enable};
	rail_sequencer_ctl_pins #(.TICK_CYCLES(TICK)) dut_u (.clk(clk), .rst_n(rst_n),
		.ctl_pins(pins), .rail_pg(rail_pg), .od_i(od_i), .od_o(), .od_oe(od_oe),
		.rail_enable(rail_enable), .auxiliary_load_switch_en(aux_en),
		.memory_buck_code(mem_code), .transceiver_ldo_code(xcvr_code), .apb_req(req),
		.apb_rsp(rsp));
	rail_env_model env_u (.clk(clk), .rail_enable(rail_enable), .od_oe(od_oe),
		.slow(slow), .pg_block(pg_block), .rail_pg(rail_pg), .od_i(od_i));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ----
	// tasks
	// ----
	task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		@(posedge clk);
		while (rsp.pready !== 1'b1)
			@(posedge clk);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
		exp_q.push_back({e, d});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wait_obs(input int idx, input logic v, output int cnt);
		cnt = 0;
		while (obs[idx] !== v && cnt < 1000) begin
			@(posedge clk);
			cnt++;
		end
	endtask
	always @(posedge clk) begin
		if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) begin
			if (exp_q.size() == 0)
				check("stray read", 40'h1, 40'h0);
			else
				check("read word", {rsp.pslverr, rsp.prdata}, exp_q.pop_front());
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles > 8000) begin
			err_count++;
			wrap_up();
		end
	end
	// ----
	// scenarios
	// ----
	initial begin
		seed = 49;
		err_count = 0;
		n_compared = 0;
		cycles = 0;
		rst_n = 1'b0;
		slow = 1'b0;
		pg_block = '0;
		req = '0;
		pins = 6'h15;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 4; i++) begin
			rd(`REG_ACTIVE_CODE + 8'(4 * i), 32'h0, 1'b0);
			wd[i] = $random(seed);
			apb(1'b1, `REG_ACTIVE_CODE + 8'(4 * i), wd[i]);
			rd(`REG_ACTIVE_CODE + 8'(4 * i), {24'h0, wd[i][7:0]}, 1'b0);
		end
		check("xcvr code", xcvr_code, wd[2][7:0]);
		check("mem code low", mem_code, wd[1][7:0]);
		rd(8'h40, 32'h0, 1'b1);
		apb(1'b1, `REG_CTRL, 32'h1);
		check("spare released", obs[14], 1'b0);
		rd(`REG_CTRL, 32'h1, 1'b0);
		pins.ddr_voltage_select <= 1'b1;
		repeat (5) @(posedge clk);
		check("mem code high", mem_code, wd[0][7:0]);
		for (int i = 0; i < 6; i++) begin
			pins.aux_switch_enable_input <= 1'($random(seed));
			repeat (5) @(posedge clk);
			check("aux switch", aux_en, pins.aux_switch_enable_input);
		end
		$display("test registers and aux done");
		slow <= 1'b1;
		pg_block <= 13'h0008;
		pins.power_enable_input <= 1'b1;
		repeat (80) @(posedge clk);
		check("chain stall", obs[4:3], 2'b01);
		check("reset held", od_oe.processor_reset_output, 1'b1);
		pg_block <= '0;
		wait_obs(12, 1'b1, n);
		check("rails up", rail_enable, 13'h1fff);
		check("switches on", {obs[16], obs[13]}, 2'b00);
		wait_obs(15, 1'b0, n);
		check("first release", n >= 50 * TICK && n <= 50 * TICK + 30, 1'b1);
		rd(`REG_PG, 32'h0000_1fff, 1'b0);
		pins.reset_request_input <= 1'b0;
		repeat (6) @(posedge clk);
		check("reset forced", {obs[15], rail_enable}, {1'b1, 13'h1fff});
		pins.reset_request_input <= 1'b1;
		wait_obs(15, 1'b0, n);
		check("reset release", n >= 50 * TICK && n <= 50 * TICK + 8, 1'b1);
		$display("test power-up done");
		for (int i = 0; i < 2; i++) begin
			pins <= pins & ~(i ? 6'h10 : 6'h04);
			repeat (6) @(posedge clk);
			check("domain off", {obs[i ? 16 : 13], rail_enable},
				{1'b1, 13'h1fff & ~(i ? `LOGIC_MASK : `FP_MASK)});
			pins <= pins | (i ? 6'h10 : 6'h04);
			wait_obs(i ? 12 : 7, 1'b1, n);
			check("domain back", rail_enable, 13'h1fff);
		end
		$display("test domains done");
		slow <= 1'b0;
		pins.power_enable_input <= 1'b0;
		repeat (5) @(posedge clk);
		check("reset first", {obs[15], obs[0]}, 2'b11);
		wait_obs(4, 1'b0, n);
		check("stage 2 ms", n >= 2 * TICK && n <= 2 * TICK + 6, 1'b1);
		wait_obs(0, 1'b0, n);
		check("stage 4 ms", n >= 4 * TICK && n <= 4 * TICK + 4, 1'b1);
		check("all off", rail_enable, 13'h0);
		$display("test power-down done");
		pins.power_enable_input <= 1'b1;
		repeat (20) @(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		check("reset state", {od_oe, rail_enable, aux_en, mem_code, xcvr_code},
			{4'hf, 13'h0, 1'b0, 16'h0});
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`REG_SHARED, 32'h0, 1'b0);
		$display("test second reset done");
		wrap_up();
	end
endmodule // rail_sequencer_ctl_pins_tb
`default_nettype wire
